/* File: rdeq_pkg.sv */
// Purpose: Constants and types for the redriver equalization strap and register loader
// Assumes: One 20 MHz clock, APB register access, two-bit level codes from comparators
// Notes:   Register offsets are byte addresses, one 32-bit word each
//
// How it works
// - Four-level straps are captured on enable rising edge and held until the next.
// - After capture, strap pull resistors are switched off to save power.
// - Each strap resolves to strong low, weak low, open, strong high as 0..3.
// - Equalization index equals four times upper strap level plus lower level.
// - System and connector receivers use separate strap pairs.
// - Register mode takes the sixteen settings from per-receiver selection registers.
// - Every receiver lane keeps its own equalization selection in register mode; straps set both lanes of a side alike.
// - System-facing receivers use fixed equalization only.
// - Connector receivers support fixed and full adaptive from straps, and fixed, fast and full from registers.
// - Fixed mode applies one selected setting whatever is attached.
// - Fast mode classifies short or long and applies that class's setting.
// - Full mode restarts the equalization search on every device insertion once straps are captured.
// - Single-lane link detected powers down the unused lane.
// - Connector transmit path always linear; system transmit limited only by register bit.
// - Limited drive offers four pre-shoot and four de-emphasis levels.
// - Fast adaptive mode is selectable only in register mode.
// - In strap mode, full adaptive follows the latched active-low enable strap.
package rdeq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] RDEQ_OFS_CTRL   = 12'h000;
  localparam logic [11:0] RDEQ_OFS_EQSEL  = 12'h004;
  localparam logic [11:0] RDEQ_OFS_LONGEQ = 12'h008;
  localparam logic [11:0] RDEQ_OFS_TXEQ   = 12'h00C;
  localparam logic [11:0] RDEQ_OFS_STATUS = 12'h010;

  // Control register fields and reset
  localparam int          RDEQ_CTRL_REGMODE = 0;
  localparam int          RDEQ_CTRL_AEQ_LSB = 1;
  localparam int          RDEQ_CTRL_LIMIT   = 3;
  localparam logic [3:0]  RDEQ_CTRL_RST     = 4'h0;
  localparam logic [15:0] RDEQ_EQSEL_RST    = 16'h0000;
  localparam logic [7:0]  RDEQ_LONGEQ_RST   = 8'h00;
  localparam logic [7:0]  RDEQ_TXEQ_RST     = 8'h00;

  // Connector receiver equalization modes, field values 0..2
  typedef enum logic [1:0] {RDEQ_FIXED, RDEQ_FAST, RDEQ_FULL} rdeq_mode_e;

  // Enable, two-bit level codes of the four-level strap pins, disable strap and detector levels
  typedef struct packed {
    logic       en;
    logic [1:0] conn_eq_strap_hi;
    logic [1:0] conn_eq_strap_lo;
    logic [1:0] sys_eq_strap_hi;
    logic [1:0] sys_eq_strap_lo;
    logic       adaptive_eq_disable_strap;
    logic       dual_lane_det;
    logic       short_channel_det;
    logic       device_present;
  } rdeq_pins_s;

  // Equalization setting per receiver lane
  typedef struct packed {
    logic [3:0] conn_lane_a;
    logic [3:0] conn_lane_b;
    logic [3:0] sys_lane_a;
    logic [3:0] sys_lane_b;
  } rdeq_rx_eq_s;

  // Result pair of the connector-side equalization search
  typedef struct packed {
    logic [3:0] lane_a;
    logic [3:0] lane_b;
  } rdeq_conn_pair_s;

  // System-facing transmitter drive setup
  typedef struct packed {
    logic       limited;
    logic [1:0] preshoot_a;
    logic [1:0] deemph_a;
    logic [1:0] preshoot_b;
    logic [1:0] deemph_b;
  } rdeq_tx_drv_s;

endpackage : rdeq_pkg

/* File: rdeq_config.sv */
// Purpose: Strap latch, equalization selection and drive control of a two-lane redriver
// Assumes: Strap codes and detector levels are asynchronous; search result is on pclk
// Notes:   APB slave with zero wait states; read data prepared in the setup cycle
//
// Our own choices: the address map and the APB slave port.

module rdeq_config
  import rdeq_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire rdeq_pkg::rdeq_pins_s      pins,
  input  wire rdeq_pkg::rdeq_conn_pair_s full_eq_found,
  output logic                           strap_pull_en,
  output rdeq_pkg::rdeq_rx_eq_s          rx_eq,
  output rdeq_pkg::rdeq_mode_e           conn_eq_mode,
  output logic                           full_search_start,
  output logic                           lane_b_pwrdn,
  output rdeq_pkg::rdeq_tx_drv_s         sys_tx_drv
);
  import rdeq_pkg::*;

  localparam int PINS_W = $bits(rdeq_pins_s);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rdeq_pins_s      s1;
    rdeq_pins_s      s2;
    rdeq_pins_s      s3;
    rdeq_pins_s      filt;
    logic            en_prev;
    logic            dev_prev;
    logic            latched;
    rdeq_rx_eq_s     strap_eq;
    logic            strap_aeq_dis;
    logic [3:0]      ctrl;
    rdeq_rx_eq_s     eq_sel;
    rdeq_conn_pair_s long_eq;
    logic [7:0]      txeq;
    rdeq_rx_eq_s     eq_o;
    rdeq_mode_e      mode_o;
    logic            search_o;
    logic            pwrdn_o;
    rdeq_tx_drv_s    tx_o;
    logic [31:0]     rdata;
    logic            slverr;
  } rdeq_state_s;

  rdeq_state_s st_r;
  rdeq_state_s st_nxt;

  logic [PINS_W-1:0] agree;
  logic              en_rise;
  logic              dev_rise;
  logic              reg_mode;
  rdeq_mode_e        mode_eff;
  rdeq_rx_eq_s       src_eq;
  logic              mapped;
  logic [31:0]       rd_mux;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Three-stage synchroniser on every pin code
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Accept a change only once stages two and three agree
    agree       = ~(st_r.s2 ^ st_r.s3);
    st_nxt.filt = (st_r.s3 & agree) | (st_r.filt & ~agree);

    en_rise         = st_r.filt.en & ~st_r.en_prev;
    dev_rise        = st_r.filt.device_present & ~st_r.dev_prev;
    st_nxt.en_prev  = st_r.filt.en;
    st_nxt.dev_prev = st_r.filt.device_present;

    // Strap capture on enable rise, held until the next rise
    if (en_rise) begin
      st_nxt.latched = 1'b1;
      // Level codes 0..3 concatenated give 4*upper+lower
      // Two-bit codes in level order
      st_nxt.strap_eq.conn_lane_a = {st_r.filt.conn_eq_strap_hi,
                                     st_r.filt.conn_eq_strap_lo};
      st_nxt.strap_eq.conn_lane_b = {st_r.filt.conn_eq_strap_hi,
                                     st_r.filt.conn_eq_strap_lo};
      st_nxt.strap_eq.sys_lane_a  = {st_r.filt.sys_eq_strap_hi,
                                     st_r.filt.sys_eq_strap_lo};
      st_nxt.strap_eq.sys_lane_b  = {st_r.filt.sys_eq_strap_hi,
                                     st_r.filt.sys_eq_strap_lo};
      st_nxt.strap_aeq_dis = st_r.filt.adaptive_eq_disable_strap;
    end else if (!st_r.filt.en) begin
      st_nxt.latched = 1'b0; // Pulls back on for the next capture
    end

    // APB register access
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      RDEQ_OFS_CTRL:   rd_mux[3:0]  = st_r.ctrl;
      RDEQ_OFS_EQSEL:  rd_mux[15:0] = st_r.eq_sel;
      RDEQ_OFS_LONGEQ: rd_mux[7:0]  = st_r.long_eq;
      RDEQ_OFS_TXEQ:   rd_mux[7:0]  = st_r.txeq;
      RDEQ_OFS_STATUS: rd_mux[23:0] = {st_r.eq_o, st_r.mode_o, st_r.filt.short_channel_det,
                                       st_r.filt.dual_lane_det, st_r.strap_aeq_dis,
                                       st_r.pwrdn_o, st_r.tx_o.limited, st_r.latched};
      default:         mapped = 1'b0;
    endcase
    if (psel && !penable) begin
      st_nxt.rdata  = pwrite ? 32'h0000_0000 : rd_mux;
      st_nxt.slverr = !mapped || (pwrite && paddr == RDEQ_OFS_STATUS);
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        RDEQ_OFS_CTRL:   st_nxt.ctrl    = pwdata[3:0];
        RDEQ_OFS_EQSEL:  st_nxt.eq_sel  = pwdata[15:0];
        RDEQ_OFS_LONGEQ: st_nxt.long_eq = pwdata[7:0];
        RDEQ_OFS_TXEQ:   st_nxt.txeq    = pwdata[7:0];
        default:         st_nxt.ctrl    = st_r.ctrl;
      endcase
    end
    // Strap values seed the selection registers, after any write
    if (en_rise) begin
      st_nxt.eq_sel = st_nxt.strap_eq;
    end

    // Effective connector equalization mode
    reg_mode = st_r.ctrl[RDEQ_CTRL_REGMODE];
    if (reg_mode) begin
      case (st_r.ctrl[RDEQ_CTRL_AEQ_LSB +: 2])
        2'h1:    mode_eff = RDEQ_FAST;
        2'h2:    mode_eff = RDEQ_FULL;
        default: mode_eff = RDEQ_FIXED;
      endcase
    end else begin
      mode_eff = st_r.strap_aeq_dis ? RDEQ_FIXED : RDEQ_FULL;
    end
    st_nxt.mode_o = mode_eff;

    // Setting source: straps or registers
    src_eq = reg_mode ? st_r.eq_sel : st_r.strap_eq;
    st_nxt.eq_o.sys_lane_a = src_eq.sys_lane_a;
    st_nxt.eq_o.sys_lane_b = src_eq.sys_lane_b;
    case (mode_eff)
      RDEQ_FAST: begin
        if (st_r.filt.short_channel_det) begin
          st_nxt.eq_o.conn_lane_a = src_eq.conn_lane_a;
          st_nxt.eq_o.conn_lane_b = src_eq.conn_lane_b;
        end else begin
          st_nxt.eq_o.conn_lane_a = st_r.long_eq.lane_a;
          st_nxt.eq_o.conn_lane_b = st_r.long_eq.lane_b;
        end
      end
      RDEQ_FULL: begin
        st_nxt.eq_o.conn_lane_a = full_eq_found.lane_a;
        st_nxt.eq_o.conn_lane_b = full_eq_found.lane_b;
      end
      default: begin
        st_nxt.eq_o.conn_lane_a = src_eq.conn_lane_a;
        st_nxt.eq_o.conn_lane_b = src_eq.conn_lane_b;
      end
    endcase

    // Restart the search on each insertion in full mode once straps are latched
    st_nxt.search_o = st_r.latched && dev_rise && mode_eff == RDEQ_FULL;

    // Unused lane off when only one lane trains
    st_nxt.pwrdn_o = st_r.latched && !st_r.filt.dual_lane_det;

    // Limited drive and transmit equalization, register mode only
    st_nxt.tx_o.limited = reg_mode && st_r.ctrl[RDEQ_CTRL_LIMIT];
    if (st_nxt.tx_o.limited) begin
      {st_nxt.tx_o.preshoot_a, st_nxt.tx_o.deemph_a,
       st_nxt.tx_o.preshoot_b, st_nxt.tx_o.deemph_b} = st_r.txeq;
    end else begin
      {st_nxt.tx_o.preshoot_a, st_nxt.tx_o.deemph_a,
       st_nxt.tx_o.preshoot_b, st_nxt.tx_o.deemph_b} = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.ctrl    <= RDEQ_CTRL_RST;
      st_r.eq_sel  <= RDEQ_EQSEL_RST;
      st_r.long_eq <= RDEQ_LONGEQ_RST;
      st_r.txeq    <= RDEQ_TXEQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign pready            = 1'b1;
  assign prdata            = st_r.rdata;
  assign pslverr           = st_r.slverr;
  assign strap_pull_en     = !st_r.latched;
  assign rx_eq             = st_r.eq_o;
  assign conn_eq_mode      = st_r.mode_o;
  assign full_search_start = st_r.search_o;
  assign lane_b_pwrdn      = st_r.pwrdn_o;
  assign sys_tx_drv        = st_r.tx_o;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !en_rise |=> $stable(st_r.strap_eq))
    else $error("strap values changed without enable rise");

  a_pull_release: assert property (@(posedge pclk) disable iff (!presetn)
    en_rise |=> !strap_pull_en [*2])
    else $error("pulls not released after capture");

  a_eq_index: assert property (@(posedge pclk) disable iff (!presetn)
    en_rise |=> st_r.strap_eq.sys_lane_a ==
      4 * $past(st_r.filt.sys_eq_strap_hi) + $past(st_r.filt.sys_eq_strap_lo))
    else $error("strap index not four times upper plus lower");

  a_strap_init: assert property (@(posedge pclk) disable iff (!presetn)
    en_rise |=> st_r.eq_sel == st_r.strap_eq)
    else $error("selection registers not seeded from straps");

  a_sys_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    reg_mode ##1 reg_mode |-> rx_eq.sys_lane_b == $past(st_r.eq_sel.sys_lane_b))
    else $error("system lane not on its fixed selection");

  a_fast_strap: assert property (@(posedge pclk) disable iff (!presetn)
    !reg_mode |=> conn_eq_mode != RDEQ_FAST)
    else $error("fast adaptive chosen in strap mode");

  a_fast_long: assert property (@(posedge pclk) disable iff (!presetn)
    mode_eff == RDEQ_FAST && !st_r.filt.short_channel_det
      |=> rx_eq.conn_lane_a == $past(st_r.long_eq.lane_a))
    else $error("long channel setting not applied");

  a_full_rerun: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.latched && dev_rise && mode_eff == RDEQ_FULL
      |=> full_search_start ##1 !full_search_start)
    else $error("search not restarted as one pulse on insertion");

  a_lane_pwrdn: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.latched && !st_r.filt.dual_lane_det |=> lane_b_pwrdn)
    else $error("unused lane left powered");

  a_limit_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !(reg_mode && st_r.ctrl[RDEQ_CTRL_LIMIT]) |=> !sys_tx_drv.limited && sys_tx_drv[7:0] == 8'h00)
    else $error("limited drive active without enable bit");

endmodule : rdeq_config

/* File: rdeq_board_model.sv */
// Purpose: Board straps, lane detectors and equalization search engine beside the loader
// Assumes: Straps reach the loader as two-bit comparator level codes
// Notes:   Unpulled strap codes wander every cycle instead of holding a level
module rdeq_board_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      strap_pull_en,
  input  wire logic                      full_search_start,
  input  wire rdeq_pkg::rdeq_pins_s      board,
  input  wire rdeq_pkg::rdeq_conn_pair_s search_tgt,
  output rdeq_pkg::rdeq_pins_s           pins,
  output rdeq_pkg::rdeq_conn_pair_s      full_eq_found
);
  import rdeq_pkg::*;
  logic [7:0] wander_r;
  logic [1:0] delay_r;
  // ---------------------------------------------------------------
  // Strap levels
  // ---------------------------------------------------------------
  // Resistor levels 0..3 while pulled, a moving pattern once isolated
  always_comb begin
    pins = board;
    if (!strap_pull_en) begin
      pins[11:4] = wander_r;
    end
  end
  // ---------------------------------------------------------------
  // Search engine
  // ---------------------------------------------------------------
  // Result shows four cycles after each start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wander_r <= 8'h00;
      delay_r <= 2'h0;
      full_eq_found <= '0;
    end else begin
      wander_r <= wander_r + 8'h5B;
      if (full_search_start) begin
        delay_r <= 2'h3;
      end else if (delay_r != 2'h0) begin
        delay_r <= delay_r - 2'h1;
      end
      if (delay_r == 2'h1) begin
        full_eq_found <= search_tgt;
      end
    end
  end
endmodule : rdeq_board_model

/* File: redriver_eq_strap_config_tb_top.sv */
// Purpose: Self-checking bench of the strap and register equalization loader
// Assumes: Pin filter settles within twelve clocks of a pin change
// Notes:   Integer model predicts every applied output
module redriver_eq_strap_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rdeq_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, pull_en, start, pwrdn;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [1:0]      ch, cl, sh, sl;
  logic            du;
  rdeq_pins_s      board, pins;
  rdeq_conn_pair_s tgt, found;
  rdeq_rx_eq_s     rx_eq;
  rdeq_mode_e      mode;
  rdeq_tx_drv_s    tx;
  int err_count, check_count, seed, regm, fld, lim, eqsel, longeq, txeq, found_i, adis, n;

  rdeq_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .full_eq_found(found), .strap_pull_en(pull_en),
    .rx_eq(rx_eq), .conn_eq_mode(mode), .full_search_start(start), .lane_b_pwrdn(pwrdn),
    .sys_tx_drv(tx));
  rdeq_board_model board_u (.pclk(pclk), .presetn(presetn), .strap_pull_en(pull_en),
    .full_search_start(start), .board(board), .search_tgt(tgt), .pins(pins),
    .full_eq_found(found));

  // Clock
  always #25 pclk = ~pclk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask : settle

  // One APB transfer, waiting for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp_rd, input logic exp_err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    chk(pready, 1'b1);
    chk(pslverr, exp_err);
    if (!wr) chk(prdata, exp_rd);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Predicted outputs from straps, registers and detectors
  task automatic check_all();
    int m, ca, cb;
    m = regm ? ((fld == 1 || fld == 2) ? fld : 0) : (adis ? 0 : 2);
    ca = (eqsel >> 12) & 15;
    cb = (eqsel >> 8) & 15;
    if (m == 2) begin
      ca = found_i >> 4;
      cb = found_i & 15;
    end else if (m == 1 && !board.short_channel_det) begin
      ca = longeq >> 4;
      cb = longeq & 15;
    end
    chk(pull_en, 1'b0);
    chk(mode, m);
    chk(rx_eq.conn_lane_a, ca);
    chk(rx_eq.conn_lane_b, cb);
    chk({rx_eq.sys_lane_a, rx_eq.sys_lane_b}, eqsel & 255);
    chk(pwrdn, !board.dual_lane_det);
    chk(tx.limited, regm & lim);
    if (regm & lim) chk(tx[7:0], txeq);
  endtask : check_all

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 29323;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    board = '0;
    tgt = '0;
    repeat (8) @(posedge pclk);
    chk(pull_en, 1'b1);
    chk(rx_eq, 0);
    presetn <= 1'b1;
    apb(1'b0, RDEQ_OFS_CTRL, 0, RDEQ_CTRL_RST, 1'b0);
    // Strap captures over every connector level code
    for (int i = 0; i < 6; i++) begin
      {ch, cl, sh, sl} = 8'($random(seed));
      ch = i[1:0];
      cl = ~ch;
      adis = i & 1;
      du = 1'($random(seed));
      board <= {1'b0, ch, cl, sh, sl, adis[0], du, 2'b00};
      settle();
      if (i > 0) chk(pull_en, 1'b1);
      board.en <= 1'b1;
      settle();
      eqsel = (ch * 4 + cl) * 4352 + (sh * 4 + sl) * 17;
      check_all();
      apb(1'b0, RDEQ_OFS_EQSEL, 0, eqsel, 1'b0);
      board <= board ^ 13'h0FF8;
      settle();
      check_all();
    end
    // Board sits at the receptacle, so adaptive use is allowed
    eqsel = $random(seed) & 16'hFFFF;
    longeq = $random(seed) & 8'hFF;
    txeq = $random(seed) & 8'hFF;
    apb(1'b1, RDEQ_OFS_EQSEL, eqsel, 0, 1'b0);
    apb(1'b1, RDEQ_OFS_LONGEQ, longeq, 0, 1'b0);
    apb(1'b1, RDEQ_OFS_TXEQ, txeq, 0, 1'b0);
    regm = 1;
    for (int f = 0; f < 8; f++) begin
      fld = f >> 1;
      lim = f & 1;
      board.short_channel_det <= f[0];
      board.dual_lane_det <= 1'($random(seed));
      apb(1'b1, RDEQ_OFS_CTRL, 32'(lim * 8 + fld * 2 + 1), 0, 1'b0);
      if (fld == 2) begin
        tgt <= 8'($random(seed));
        board.device_present <= 1'b0;
        settle();
        board.device_present <= 1'b1;
        n = 0;
        do begin
          @(posedge pclk);
          n++;
        end while (start !== 1'b1 && n < 30);
        chk(start, 1'b1);
        found_i = tgt;
      end
      settle();
      check_all();
    end
    apb(1'b0, 12'h014, 0, 0, 1'b1);
    apb(1'b1, RDEQ_OFS_STATUS, 32'hFFFFFFFF, 0, 1'b1);
    apb(1'b1, RDEQ_OFS_CTRL, 32'hFFFFFFF0, 0, 1'b0);
    apb(1'b0, RDEQ_OFS_CTRL, 0, 0, 1'b0);
    complete_run();
  end

  // Hang guard
  initial begin
    #(50 * 5000);
    err_count++;
    complete_run();
  end
endmodule : redriver_eq_strap_config_tb_top
